// *** rtbw_map.svh ***
// register offsets, bit positions, reset values and timing counts for the test-word block
// Contract
// - 16-bit read-only message pointer, hard reset only
// - pointer holds last valid command's buffer address
// - pointer updates 5 us after active rises
// - two 16-bit writable select registers, hard reset
// - select registers used only when auto-select zero
// - shutdown commands act only on inactive bus
// - command on bus B compares bus A select
// - bus A match on shutdown sets A flag
// - command on bus A compares bus B select
// - bus B match on shutdown sets B flag
// - test word bits 11-4 writable, rest read-only
// - hard reset clears bits, pins/faults set others
// - terminal soft reset leaves test word alone
// - transmit-test-word command sends then copies word
// - bits 15/14 flag transmitter disabled
// - bits 13/12 flag receiver disabled too
// - bits 5/4 flag loopback failures
// - bit 3 flags memory self-test failure
// - bit 2 flags terminal address parity error
// - bit 0 tracks terminal flag inhibit commands
`ifndef RTBW_MAP_SVH
`define RTBW_MAP_SVH

`define RTBW_OFS_MSG_PTR 16'h001B
`define RTBW_OFS_A_MATCH 16'h001C
`define RTBW_OFS_B_MATCH 16'h001D
`define RTBW_OFS_TEST_WORD 16'h001E

`define RTBW_RESET_WORD 16'h0000

`define RTBW_BIT_TX_A 15
`define RTBW_BIT_TX_B 14
`define RTBW_BIT_RX_A 13
`define RTBW_BIT_RX_B 12
`define RTBW_BIT_LOOP_A 5
`define RTBW_BIT_LOOP_B 4
`define RTBW_BIT_MEM 3
`define RTBW_BIT_PARITY 2
`define RTBW_BIT_INIT 1
`define RTBW_BIT_TFLAG 0
`define RTBW_WRITABLE_MASK 16'h0FF0

`define RTBW_MC_TX_SHUT 5'h04
`define RTBW_MC_TX_OVR 5'h05
`define RTBW_MC_TFLAG_INH 5'h06
`define RTBW_MC_TFLAG_OVR 5'h07
`define RTBW_MC_SEND_WORD 5'h13
`define RTBW_MC_SEL_SHUT 5'h14
`define RTBW_MC_SEL_OVR 5'h15

`define RTBW_CLK_PERIOD_NS 5
`define RTBW_UPDATE_DELAY_NS 5000
`define RTBW_UPDATE_CYCLES ((`RTBW_UPDATE_DELAY_NS + `RTBW_CLK_PERIOD_NS - 1) / `RTBW_CLK_PERIOD_NS)

`endif

// *** rtbw_pkg.sv ***
// shared types of the test-word block
package rtbw_pkg;

	typedef struct packed {
		logic write;
		logic read;
		logic [15:0] addr;
		logic [15:0] wdata;
	} rtbw_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [4:0] code;
		logic busB;
		logic [15:0] data;
	} rtbw_mode_cmd_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} rtbw_word_t;

	typedef struct packed {
		logic busy;
		logic [9:0] count;
		logic [15:0] addr;
		logic done;
		logic [15:0] doneAddr;
	} rtbw_delay_state_t;

	typedef struct packed {
		logic activePrev;
		logic [1:0] inhASync;
		logic [1:0] inhBSync;
		logic [1:0] autoInitSync;
		logic [15:0] msgPtr;
		logic [15:0] busAMatch;
		logic [15:0] busBMatch;
		logic [15:0] testWord;
		logic cmdShutA;
		logic cmdShutB;
		logic [15:0] rdata;
		rtbw_word_t txWord;
		rtbw_word_t bufWrite;
		logic copyPending;
		logic [15:0] copyWord;
		logic hostAssist;
	} rtbw_state_t;

endpackage : rtbw_pkg

// *** rtbw_delay.sv ***
// one-shot delay that releases a captured address after the update time
`include "rtbw_map.svh"

module rtbw_delay (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [15:0] startAddr,
	output logic done,
	output logic [15:0] doneAddr
);

	localparam logic [9:0] LAST_COUNT = 10'(`RTBW_UPDATE_CYCLES - 1);

	rtbw_pkg::rtbw_delay_state_t state;
	rtbw_pkg::rtbw_delay_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (start) begin
			next_state.busy = 1'b1;
			next_state.count = LAST_COUNT;
			next_state.addr = startAddr;
		end else if (state.busy) begin
			if (state.count == 10'h000) begin
				next_state.busy = 1'b0;
				next_state.done = 1'b1;
				next_state.doneAddr = state.addr;
			end else begin
				next_state.count = state.count - 10'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign done = state.done;
	assign doneAddr = state.doneAddr;

endmodule : rtbw_delay

// *** rtbw_test_word.sv ***
// remote-terminal message pointer, bus select compare and built-in test word
`include "rtbw_map.svh"

module rtbw_test_word (
	input wire logic clk,
	input wire logic reset,
	input rtbw_pkg::rtbw_reg_req_t regReq,
	output logic [15:0] regRdata,
	input wire logic activeMessage,
	input wire logic [15:0] descriptorAddr,
	input rtbw_pkg::rtbw_mode_cmd_t modeCmd,
	input wire logic modeDone,
	input wire logic autoBusShutdownSelect,
	input wire logic alternateTestWordOption,
	input wire logic shutdownAlsoRx,
	input wire logic txInhibitAPin,
	input wire logic txInhibitBPin,
	input wire logic autoInitPin,
	input wire logic loopFailA,
	input wire logic loopFailB,
	input wire logic memorySelftestFail,
	input wire logic addressParityFail,
	input wire logic initLoadFail,
	output rtbw_pkg::rtbw_word_t txWord,
	output rtbw_pkg::rtbw_word_t bufWrite,
	output logic txDisableA,
	output logic txDisableB,
	output logic rxDisableA,
	output logic rxDisableB,
	output logic terminalFlagInhibited,
	output logic hostAssist
);

	rtbw_pkg::rtbw_state_t state;
	rtbw_pkg::rtbw_state_t next_state;

	logic activeRise;
	logic ptrDone;
	logic [15:0] ptrAddr;

	logic cmdOnB;
	logic selectMatch;
	logic isSelShut;
	logic isSelOvr;
	logic autoSelShut;
	logic autoSelOvr;
	logic doShut;
	logic doOvr;

	assign activeRise = activeMessage & ~state.activePrev;

	rtbw_delay ptrDelay (
		.clk(clk),
		.reset(reset),
		.start(activeRise),
		.startAddr(descriptorAddr),
		.done(ptrDone),
		.doneAddr(ptrAddr)
	);

	always_comb begin
		cmdOnB = modeCmd.busB;
		// bus B command checks A select
		// bus A command checks B select
		selectMatch = cmdOnB ? (modeCmd.data == state.busAMatch) : (modeCmd.data == state.busBMatch);
		isSelShut = modeCmd.valid && (modeCmd.code == `RTBW_MC_SEL_SHUT);
		isSelOvr = modeCmd.valid && (modeCmd.code == `RTBW_MC_SEL_OVR);
		autoSelShut = isSelShut && !autoBusShutdownSelect && selectMatch;
		autoSelOvr = isSelOvr && !autoBusShutdownSelect && selectMatch;
		doShut = autoSelShut || (modeCmd.valid && (modeCmd.code == `RTBW_MC_TX_SHUT));
		doOvr = autoSelOvr || (modeCmd.valid && (modeCmd.code == `RTBW_MC_TX_OVR));
	end

	always_comb begin
		next_state = state;
		next_state.activePrev = activeMessage;
		next_state.txWord.valid = 1'b0;
		next_state.bufWrite.valid = 1'b0;
		next_state.hostAssist = 1'b0;

		// pins from outside the clock domain
		next_state.inhASync = {state.inhASync[0], txInhibitAPin};
		next_state.inhBSync = {state.inhBSync[0], txInhibitBPin};
		next_state.autoInitSync = {state.autoInitSync[0], autoInitPin};

		if (ptrDone) begin
			next_state.msgPtr = ptrAddr;
		end

		// host register writes
		if (regReq.write) begin
			case (regReq.addr)
				`RTBW_OFS_A_MATCH: begin
					next_state.busAMatch = regReq.wdata;
				end
				`RTBW_OFS_B_MATCH: begin
					next_state.busBMatch = regReq.wdata;
				end
				`RTBW_OFS_TEST_WORD: begin
					next_state.testWord = (state.testWord & ~`RTBW_WRITABLE_MASK)
						| (regReq.wdata & `RTBW_WRITABLE_MASK);
				end
				default: begin
				end
			endcase
		end

		if (doShut) begin
			if (cmdOnB) begin
				next_state.cmdShutA = 1'b1;
				if (shutdownAlsoRx) begin
					next_state.testWord[`RTBW_BIT_RX_A] = 1'b1;
				end
			end else begin
				next_state.cmdShutB = 1'b1;
				if (shutdownAlsoRx) begin
					next_state.testWord[`RTBW_BIT_RX_B] = 1'b1;
				end
			end
		end

		if (doOvr) begin
			if (cmdOnB) begin
				next_state.cmdShutA = 1'b0;
				next_state.testWord[`RTBW_BIT_RX_A] = 1'b0;
			end else begin
				next_state.cmdShutB = 1'b0;
				next_state.testWord[`RTBW_BIT_RX_B] = 1'b0;
			end
		end

		// selected commands left to the host
		if ((isSelShut || isSelOvr) && !(autoSelShut || autoSelOvr)) begin
			next_state.hostAssist = 1'b1;
		end

		next_state.testWord[`RTBW_BIT_TX_A] = state.inhASync[1] | next_state.cmdShutA;
		next_state.testWord[`RTBW_BIT_TX_B] = state.inhBSync[1] | next_state.cmdShutB;

		if (loopFailA) begin
			next_state.testWord[`RTBW_BIT_LOOP_A] = 1'b1;
		end
		if (loopFailB) begin
			next_state.testWord[`RTBW_BIT_LOOP_B] = 1'b1;
		end

		if (memorySelftestFail) begin
			next_state.testWord[`RTBW_BIT_MEM] = 1'b1;
		end

		next_state.testWord[`RTBW_BIT_PARITY] = addressParityFail;

		// init load failure only with auto-init
		if (initLoadFail && state.autoInitSync[1]) begin
			next_state.testWord[`RTBW_BIT_INIT] = 1'b1;
		end

		if (modeCmd.valid && (modeCmd.code == `RTBW_MC_TFLAG_INH)) begin
			next_state.testWord[`RTBW_BIT_TFLAG] = 1'b1;
		end else if (modeCmd.valid && (modeCmd.code == `RTBW_MC_TFLAG_OVR)) begin
			next_state.testWord[`RTBW_BIT_TFLAG] = 1'b0;
		end

		if (modeCmd.valid && (modeCmd.code == `RTBW_MC_SEND_WORD) && !alternateTestWordOption) begin
			next_state.txWord.valid = 1'b1;
			next_state.txWord.data = state.testWord;
			next_state.copyPending = 1'b1;
			next_state.copyWord = state.testWord;
		end else if (modeDone && state.copyPending) begin
			next_state.copyPending = 1'b0;
			next_state.bufWrite.valid = 1'b1;
			next_state.bufWrite.data = state.copyWord;
		end

		// read data, unmapped reads zero
		if (regReq.read) begin
			case (regReq.addr)
				`RTBW_OFS_MSG_PTR: begin
					next_state.rdata = state.msgPtr;
				end
				`RTBW_OFS_A_MATCH: begin
					next_state.rdata = state.busAMatch;
				end
				`RTBW_OFS_B_MATCH: begin
					next_state.rdata = state.busBMatch;
				end
				`RTBW_OFS_TEST_WORD: begin
					next_state.rdata = state.testWord;
				end
				default: begin
					next_state.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= '0;
			state.testWord <= `RTBW_RESET_WORD;
		end else begin
			state <= next_state;
		end
	end

	assign regRdata = state.rdata;
	assign txWord = state.txWord;
	assign bufWrite = state.bufWrite;
	assign txDisableA = state.testWord[`RTBW_BIT_TX_A];
	assign txDisableB = state.testWord[`RTBW_BIT_TX_B];
	assign rxDisableA = state.testWord[`RTBW_BIT_RX_A];
	assign rxDisableB = state.testWord[`RTBW_BIT_RX_B];
	assign terminalFlagInhibited = state.testWord[`RTBW_BIT_TFLAG];
	assign hostAssist = state.hostAssist;

endmodule : rtbw_test_word

// *** rtbw_test_word_properties.sv ***
// assertions on the test-word block ports
module rtbw_check (
	input wire logic clk,
	input wire logic reset,
	input rtbw_pkg::rtbw_mode_cmd_t modeCmd,
	input wire logic modeDone,
	input wire logic autoBusShutdownSelect,
	input wire logic alternateTestWordOption,
	input wire logic shutdownAlsoRx,
	input rtbw_pkg::rtbw_word_t txWord,
	input rtbw_pkg::rtbw_word_t bufWrite,
	input wire logic txDisableA,
	input wire logic txDisableB,
	input wire logic rxDisableA,
	input wire logic terminalFlagInhibited,
	input wire logic hostAssist
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_cmd(c);
		modeCmd.valid && modeCmd.code == c;
	endsequence
	tx_word_send_a: assert property (s_cmd(5'h13) ##0 !alternateTestWordOption |=> txWord.valid)
		else $error("test word not sent");
	buf_copy_done_a: assert property (bufWrite.valid |-> $past(modeDone))
		else $error("buffer copy without completion");
	auto_off_assist_a: assert property (modeCmd.valid && autoBusShutdownSelect
		&& (modeCmd.code inside {5'h14, 5'h15}) |=> hostAssist)
		else $error("no host assist with auto select off");
	assist_cause_a: assert property (hostAssist
		|-> $past(modeCmd.valid && (modeCmd.code inside {5'h14, 5'h15})))
		else $error("host assist without select command");
	inactive_a_shut_a: assert property (s_cmd(5'h04) ##0 modeCmd.busB |=> txDisableA)
		else $error("bus A not shut by command on bus B");
	inactive_b_shut_a: assert property (s_cmd(5'h04) ##0 !modeCmd.busB |=> txDisableB)
		else $error("bus B not shut by command on bus A");
	rx_kept_on_a: assert property (s_cmd(5'h04) ##0 modeCmd.busB
		&& !shutdownAlsoRx && !rxDisableA |=> !rxDisableA)
		else $error("receiver shut without receiver option");
	flag_inhibit_a: assert property (s_cmd(5'h06) |=> terminalFlagInhibited)
		else $error("terminal flag inhibit not flagged");
	flag_override_a: assert property (s_cmd(5'h07) |=> !terminalFlagInhibited)
		else $error("terminal flag inhibit not cleared");
endmodule : rtbw_check

bind rtbw_test_word rtbw_check u_check (.clk, .reset, .modeCmd, .modeDone, .autoBusShutdownSelect,
	.alternateTestWordOption, .shutdownAlsoRx, .txWord, .bufWrite, .txDisableA, .txDisableB,
	.rxDisableA, .terminalFlagInhibited, .hostAssist);

// *** rtbw_bus_ctrl.sv ***
// bus controller model issuing mode commands
module rtbw_bus_ctrl (
	input wire logic clk,
	output rtbw_pkg::rtbw_mode_cmd_t modeCmd,
	output logic modeDone
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		modeCmd = '0;
		modeDone = 1'b0;
	end
	// idle fields inverted so stale values never look valid
	task automatic send(input logic [4:0] code, input logic onB, input logic [15:0] data, input int gap);
		@(posedge clk);
		modeCmd <= '{1'b1, code, onB, data};
		@(posedge clk);
		modeCmd <= '{1'b0, ~code, ~onB, ~data};
		repeat (gap) @(posedge clk);
		modeDone <= 1'b1;
		@(posedge clk);
		modeDone <= 1'b0;
	endtask : send
endmodule : rtbw_bus_ctrl

// *** rtbw_test_word_bench.sv ***
// self-checking bench for the test-word block
module rtbw_test_word_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, activeMessage, modeDone, autoBusShutdownSelect, alternateTestWordOption;
	logic shutdownAlsoRx, txInhibitAPin, txInhibitBPin, autoInitPin, loopFailA, loopFailB;
	logic memorySelftestFail, addressParityFail, initLoadFail, txDisableA, txDisableB;
	logic rxDisableA, rxDisableB, terminalFlagInhibited, hostAssist;
	logic [15:0] regRdata, descriptorAddr, lastTx, lastBuf;
	rtbw_pkg::rtbw_reg_req_t regReq;
	rtbw_pkg::rtbw_mode_cmd_t modeCmd;
	rtbw_pkg::rtbw_word_t txWord, bufWrite;
	int mismatches, nChecks, assists;
	rtbw_test_word u_rtbw_test_word (.clk, .reset, .regReq, .regRdata, .activeMessage, .descriptorAddr,
		.modeCmd, .modeDone, .autoBusShutdownSelect, .alternateTestWordOption, .shutdownAlsoRx,
		.txInhibitAPin, .txInhibitBPin, .autoInitPin, .loopFailA, .loopFailB, .memorySelftestFail,
		.addressParityFail, .initLoadFail, .txWord, .bufWrite, .txDisableA, .txDisableB,
		.rxDisableA, .rxDisableB, .terminalFlagInhibited, .hostAssist);
	rtbw_bus_ctrl u_rtbw_bus_ctrl (.clk, .modeCmd, .modeDone);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (txWord.valid) lastTx <= txWord.data;
		if (bufWrite.valid) lastBuf <= bufWrite.data;
		if (hostAssist) assists <= assists + 1;
	end
	function automatic logic [15:0] outs();
		return {11'h000, txDisableA, txDisableB, rxDisableA, rxDisableB, terminalFlagInhibited};
	endfunction : outs
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		regReq <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		regReq.write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		regReq <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		regReq.read <= 1'b0;
		#1;
		check($sformatf("register %h", a), regRdata, exp);
	endtask : rd
	task automatic send(input logic [4:0] c, input logic b, input logic [15:0] d, input int g);
		u_rtbw_bus_ctrl.send(c, b, d, g);
		#1;
	endtask : send
	task automatic testRegs();
		rd(16'h001B, 16'h0000);
		rd(16'h001E, 16'h0000);
		rd(16'h0020, 16'h0000);
		wr(16'h001C, 16'h1234);
		wr(16'h001D, 16'hABCD);
		wr(16'h001B, 16'hFFFF);
		wr(16'h001E, 16'hFFFF);
		rd(16'h001C, 16'h1234);
		rd(16'h001D, 16'hABCD);
		rd(16'h001B, 16'h0000);
		rd(16'h001E, 16'h0FF0);
		wr(16'h001E, 16'h0000);
		$display("registers done");
	endtask : testRegs
	task automatic testPointer();
		@(posedge clk);
		activeMessage <= 1'b1;
		descriptorAddr <= 16'h0456;
		@(posedge clk);
		descriptorAddr <= 16'h0000;
		repeat (999) @(posedge clk);
		activeMessage <= 1'b0;
		rd(16'h001B, 16'h0000);
		rd(16'h001B, 16'h0456);
		$display("pointer done");
	endtask : testPointer
	task automatic testShutdown();
		shutdownAlsoRx <= 1'b1;
		send(5'h14, 1'b1, 16'h1234, 2);
		check("disables", outs(), 16'h0014);
		rd(16'h001E, 16'hA000);
		send(5'h15, 1'b1, 16'h1234, 2);
		check("disables", outs(), 16'h0000);
		send(5'h14, 1'b0, 16'hABCD, 0);
		check("disables", outs(), 16'h000A);
		rd(16'h001E, 16'h5000);
		send(5'h14, 1'b0, 16'h1234, 0);
		check("assists", 16'(assists), 16'h0001);
		autoBusShutdownSelect <= 1'b1;
		send(5'h15, 1'b0, 16'hABCD, 0);
		check("disables", outs(), 16'h000A);
		autoBusShutdownSelect <= 1'b0;
		send(5'h15, 1'b0, 16'hABCD, 0);
		check("disables", outs(), 16'h0000);
		shutdownAlsoRx <= 1'b0;
		send(5'h04, 1'b1, 16'h0000, 0);
		check("disables", outs(), 16'h0010);
		send(5'h05, 1'b1, 16'h0000, 0);
		check("disables", outs(), 16'h0000);
		$display("shutdown done");
	endtask : testShutdown
	task automatic testWord();
		wr(16'h001E, 16'h0AC0);
		@(posedge clk);
		{loopFailA, loopFailB, memorySelftestFail, initLoadFail, addressParityFail} <= 5'h1F;
		@(posedge clk);
		{loopFailA, loopFailB, memorySelftestFail, initLoadFail} <= 4'h0;
		send(5'h06, 1'b0, 16'h0000, 0);
		rd(16'h001E, 16'h0AFF);
		alternateTestWordOption <= 1'b1;
		send(5'h13, 1'b0, 16'h0000, 0);
		check("alternate word", lastTx, 16'h0000);
		alternateTestWordOption <= 1'b0;
		send(5'h13, 1'b0, 16'h0000, 3);
		repeat (2) @(posedge clk);
		check("sent word", lastTx, 16'h0AFF);
		check("copied word", lastBuf, 16'h0AFF);
		send(5'h07, 1'b1, 16'h0000, 0);
		addressParityFail <= 1'b0;
		wr(16'h001E, 16'h0000);
		rd(16'h001E, 16'h000A);
		check("disables", outs(), 16'h0000);
		txInhibitBPin <= 1'b1;
		repeat (5) @(posedge clk);
		check("disables", outs(), 16'h0008);
		rd(16'h001E, 16'h400A);
		$display("test word done");
	endtask : testWord
	task automatic testReset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(16'h001C, 16'h0000);
		rd(16'h001B, 16'h0000);
		rd(16'h001E, 16'h4000);
		$display("reset done");
	endtask : testReset
	task automatic stopTest();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stopTest
	initial begin
		regReq = '0;
		reset = 1'b1;
		{activeMessage, autoBusShutdownSelect, alternateTestWordOption, shutdownAlsoRx} = 4'h0;
		{txInhibitAPin, txInhibitBPin, loopFailA, loopFailB, memorySelftestFail} = 5'h00;
		{addressParityFail, initLoadFail, autoInitPin} = 3'h1;
		descriptorAddr = 16'h0000;
		{lastTx, lastBuf} = 32'h0;
		{mismatches, nChecks, assists} = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		testRegs();
		testPointer();
		testShutdown();
		testWord();
		testReset();
		stopTest();
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stopTest();
	end
endmodule : rtbw_test_word_bench
